// ---- logic/sdc_pkg.sv ----
`default_nettype none
package sdc_pkg;
    // link frame
    localparam int unsigned FRAME_BITS = 8;
    localparam int unsigned ADDR_BITS  = 3;
    localparam int unsigned DATA_BITS  = 5;
    localparam int unsigned NCH        = 2;
    localparam logic [3:0]  FRAME_CNT  = 4'h8;
    localparam logic [3:0]  CNT_MAX    = 4'hf;

    // register addresses on the link
    localparam logic [2:0] A_RESET  = 3'h0;
    localparam logic [2:0] A_CLOCK  = 3'h1;
    localparam logic [2:0] A_DATA   = 3'h2;
    localparam logic [2:0] A_SUPPLY = 3'h3;

    // field positions: low field bits 1:0, high field bits 3:2
    localparam int unsigned F_LO = 0;
    localparam int unsigned F_HI = 2;

    // reset values
    localparam logic [4:0] RST_RESET  = 5'h00;
    localparam logic [4:0] RST_CLOCK  = 5'h03;
    localparam logic [4:0] RST_DATA   = 5'h00;
    localparam logic [4:0] RST_SUPPLY = 5'h00;

    // synchroniser vector positions
    localparam int unsigned S_SEL  = 0;
    localparam int unsigned S_SCK  = 1;
    localparam int unsigned S_SDA  = 2;
    localparam int unsigned S_HRST = 3;
    localparam int unsigned S_HCLK = 5;
    localparam int unsigned S_HIO  = 7;
    localparam int unsigned S_CIO  = 9;
    localparam int unsigned S_W    = 11;

    // host apb map
    localparam int unsigned APB_AW   = 8;
    localparam logic [7:0]  R_FRAME  = 8'h00;
    localparam logic [7:0]  R_STATUS = 8'h04;
    localparam int unsigned ST_BUSY  = 0;
    localparam int unsigned ST_REFU  = 1;

    // link timing
    localparam int unsigned PCLK_NS  = 50;
    localparam int unsigned HALF_NS  = 200;
    localparam int unsigned HALF_CYC = (HALF_NS + PCLK_NS - 1) / PCLK_NS;

    typedef enum logic [1:0] {
        IO_IDLE   = 2'h0,
        IO_HOST   = 2'h1,
        IO_SETTLE = 2'h3,
        IO_CARD   = 2'h2
    } sdc_io_st_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LEAD = 3'h1,
        H_HIGH = 3'h3,
        H_LOW  = 3'h2,
        H_TAIL = 3'h6,
        H_GAP  = 3'h4
    } sdc_host_st_t;

    typedef struct packed {
        logic [S_W-1:0]        s1;
        logic [S_W-1:0]        s2;
        logic                  sck_prev;
        logic                  sel_prev;
        logic [7:0]            shift;
        logic [3:0]            cnt;
        logic [4:0]            rst_reg;
        logic [4:0]            clk_reg;
        logic [4:0]            dat_reg;
        logic [4:0]            sup_reg;
        logic [NCH-1:0]        rst_out;
        logic [NCH-1:0]        clk_out;
        logic [NCH-1:0]        cio_oe_n;
        logic [NCH-1:0]        hio_oe_n;
        sdc_io_st_t [NCH-1:0]  io_st;
    } sdc_dev_state_t;

    typedef struct packed {
        sdc_host_st_t st;
        logic [15:0]  div;
        logic [3:0]   bits;
        logic [7:0]   shift;
        logic [7:0]   frame;
        logic         refused;
        logic         sel_n;
        logic         sck;
        logic         sdat;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } sdc_host_state_t;
endpackage
`default_nettype wire

// ---- logic/sdc_link_if.sv ----
`default_nettype none
interface sdc_link_if;
    logic host_select_n;
    logic serial_clock_in;
    logic serial_data_in;

    modport host (
        output host_select_n,
        output serial_clock_in,
        output serial_data_in
    );
    modport dev (
        input  host_select_n,
        input  serial_clock_in,
        input  serial_data_in
    );
endinterface
`default_nettype wire

// ---- logic/sdc_dev.sv ----
// Notes on behaviour
// - every frame is eight bits, write only
// - host idles clock low, select high
// - select stays low through whole frame
// - first three bits address, five data
// - address decodes reset, clock, data, supply
// - low bit channel one, high channel two
// - supply on, select 0: reset follows host
// - supply on, select 1: reset forced value
// - clock code 01 pass, 11 high, 00 low
// - data disabled: both sides disconnected, pulled high
// - data enabled: sides joined both ways
// - force low bit drives card io low
// - supply off: all card outputs zero
// - supply register: enable and level fields
`default_nettype none
module sdc_dev (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // serial link
    sdc_link_if.dev                     link,
    // baseband card signals
    input  wire logic [sdc_pkg::NCH-1:0] host_card_reset,
    input  wire logic [sdc_pkg::NCH-1:0] host_card_clock,
    input  wire logic [sdc_pkg::NCH-1:0] host_card_io_i,
    output logic      [sdc_pkg::NCH-1:0] host_card_io_o,
    output logic      [sdc_pkg::NCH-1:0] host_card_io_oe_n,
    // card side
    output logic      [sdc_pkg::NCH-1:0] card_reset_out,
    output logic      [sdc_pkg::NCH-1:0] card_clock_out,
    input  wire logic [sdc_pkg::NCH-1:0] card_io_i,
    output logic      [sdc_pkg::NCH-1:0] card_io_o,
    output logic      [sdc_pkg::NCH-1:0] card_io_oe_n,
    // supply control
    output logic      [sdc_pkg::NCH-1:0] card_supply_enable,
    output logic      [sdc_pkg::NCH-1:0] supply_level_select
);

    sdc_pkg::sdc_dev_state_t q;
    sdc_pkg::sdc_dev_state_t d;

    // one channel bit of a two-bit field
    function automatic logic fbit(input logic [4:0] r, input int unsigned lsb,
                                  input int unsigned ch);
        fbit = r[lsb + ch];
    endfunction

    logic                    sel_n;
    logic                    sck;
    logic                    sda;
    logic                    sck_rise;
    logic [2:0]              waddr;
    logic [4:0]              wdata;
    logic                    en;
    logic                    path;
    logic                    hl;
    logic                    cl;
    logic [1:0]              ccode;

    always_comb begin
        d = q;
        d.s1 = {card_io_i, host_card_io_i, host_card_clock, host_card_reset,
                link.serial_data_in, link.serial_clock_in, link.host_select_n};
        d.s2 = q.s1;
        sel_n = q.s2[sdc_pkg::S_SEL];
        sck   = q.s2[sdc_pkg::S_SCK];
        sda   = q.s2[sdc_pkg::S_SDA];
        d.sck_prev = sck;
        d.sel_prev = sel_n;
        sck_rise = sck & ~q.sck_prev;
        waddr = q.shift[sdc_pkg::FRAME_BITS-1 -: sdc_pkg::ADDR_BITS];
        wdata = q.shift[sdc_pkg::DATA_BITS-1:0];

        // frame assembly
        if (!sel_n && q.sel_prev) begin
            d.cnt = '0;
        end else if (!sel_n && sck_rise) begin
            d.shift = {q.shift[sdc_pkg::FRAME_BITS-2:0], sda};
            if (q.cnt != sdc_pkg::CNT_MAX) begin
                d.cnt = q.cnt + 4'h1;
            end
        end else if (sel_n && !q.sel_prev) begin
            d.cnt = '0;
            if (q.cnt == sdc_pkg::FRAME_CNT) begin
                case (waddr)
                    sdc_pkg::A_RESET:  d.rst_reg = wdata;
                    sdc_pkg::A_CLOCK:  d.clk_reg = wdata;
                    sdc_pkg::A_DATA:   d.dat_reg = wdata;
                    sdc_pkg::A_SUPPLY: d.sup_reg = wdata;
                    default: ;
                endcase
            end
        end

        for (int unsigned ch = 0; ch < sdc_pkg::NCH; ch++) begin
            en   = fbit(q.sup_reg, sdc_pkg::F_HI, ch);
            path = en & fbit(q.dat_reg, sdc_pkg::F_LO, ch)
                 & ~fbit(q.dat_reg, sdc_pkg::F_HI, ch);
            hl   = ~q.s2[sdc_pkg::S_HIO + ch];
            cl   = ~q.s2[sdc_pkg::S_CIO + ch];
            ccode = {fbit(q.clk_reg, sdc_pkg::F_HI, ch),
                     fbit(q.clk_reg, sdc_pkg::F_LO, ch)};

            // reset pin
            if (!en) begin
                d.rst_out[ch] = 1'b0;
            end else if (!fbit(q.rst_reg, sdc_pkg::F_LO, ch)) begin
                d.rst_out[ch] = q.s2[sdc_pkg::S_HRST + ch];
            end else begin
                d.rst_out[ch] = fbit(q.rst_reg, sdc_pkg::F_HI, ch);
            end

            // clock pin
            if (!en) begin
                d.clk_out[ch] = 1'b0;
            end else begin
                case (ccode)
                    2'h1:    d.clk_out[ch] = q.s2[sdc_pkg::S_HCLK + ch];
                    2'h3:    d.clk_out[ch] = 1'b1;
                    default: d.clk_out[ch] = 1'b0;
                endcase
            end

            // data direction tracking: whoever pulls low first owns the path
            case (q.io_st[ch])
                sdc_pkg::IO_IDLE: begin
                    if (path && hl) begin
                        d.io_st[ch] = sdc_pkg::IO_HOST;
                    end else if (path && cl) begin
                        d.io_st[ch] = sdc_pkg::IO_CARD;
                    end
                end
                sdc_pkg::IO_HOST: begin
                    if (!path || !hl) begin
                        d.io_st[ch] = sdc_pkg::IO_SETTLE;
                    end
                end
                sdc_pkg::IO_CARD: begin
                    if (!path || !cl) begin
                        d.io_st[ch] = sdc_pkg::IO_SETTLE;
                    end
                end
                sdc_pkg::IO_SETTLE: begin
                    // wait for the echo of our own drive to clear
                    if (!path || (!hl && !cl)) begin
                        d.io_st[ch] = sdc_pkg::IO_IDLE;
                    end
                end
                default: d.io_st[ch] = sdc_pkg::IO_IDLE;
            endcase

            if (!en) begin
                d.cio_oe_n[ch] = 1'b0;
                d.hio_oe_n[ch] = 1'b1;
            end else if (!fbit(q.dat_reg, sdc_pkg::F_LO, ch)) begin
                d.cio_oe_n[ch] = 1'b1;
                d.hio_oe_n[ch] = 1'b1;
            end else if (fbit(q.dat_reg, sdc_pkg::F_HI, ch)) begin
                d.cio_oe_n[ch] = 1'b0;
                d.hio_oe_n[ch] = 1'b1;
            end else begin
                d.cio_oe_n[ch] = ~(d.io_st[ch] == sdc_pkg::IO_HOST);
                d.hio_oe_n[ch] = ~(d.io_st[ch] == sdc_pkg::IO_CARD);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.sck_prev <= 1'b0;
            q.sel_prev <= 1'b1;
            q.s1       <= {sdc_pkg::S_W{1'b1}} & ~(11'h2);
            q.s2       <= {sdc_pkg::S_W{1'b1}} & ~(11'h2);
            q.rst_reg  <= sdc_pkg::RST_RESET;
            q.clk_reg  <= sdc_pkg::RST_CLOCK;
            q.dat_reg  <= sdc_pkg::RST_DATA;
            q.sup_reg  <= sdc_pkg::RST_SUPPLY;
            q.cio_oe_n <= '0;
            q.hio_oe_n <= '1;
        end else begin
            q <= d;
        end
    end

    assign card_reset_out      = q.rst_out;
    assign card_clock_out      = q.clk_out;
    assign card_io_oe_n        = q.cio_oe_n;
    assign card_io_o           = q.rst_out & '0;
    assign host_card_io_oe_n   = q.hio_oe_n;
    assign host_card_io_o      = q.clk_out & '0;
    assign card_supply_enable  = q.sup_reg[sdc_pkg::F_HI +: sdc_pkg::NCH];
    assign supply_level_select = q.sup_reg[sdc_pkg::F_LO +: sdc_pkg::NCH];

endmodule
`default_nettype wire

// ---- logic/sdc_host.sv ----
`default_nettype none
module sdc_host #(
    parameter int unsigned HALF_CYC = sdc_pkg::HALF_CYC
) (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [sdc_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // serial link
    sdc_link_if.host                        link
);

    if (HALF_CYC < 1 || HALF_CYC > 65535) begin : g_chk
        $error("sdc_host: HALF_CYC out of range");
    end

    localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);

    sdc_pkg::sdc_host_state_t q;
    sdc_pkg::sdc_host_state_t d;

    logic busy;
    logic bad_clk;
    logic acc;

    always_comb begin
        d = q;
        busy = (q.st != sdc_pkg::H_IDLE);
        acc  = psel & penable;
        // clock code 10 must never reach the device
        bad_clk = (pwdata[7:5] == sdc_pkg::A_CLOCK) &&
                  (|(pwdata[sdc_pkg::F_HI +: 2] & ~pwdata[sdc_pkg::F_LO +: 2]));

        // apb: one wait cycle, effects at the edge where pready is high
        d.pready  = acc & ~q.pready;
        d.pslverr = 1'b0;
        if (acc && !q.pready) begin
            d.prdata = '0;
            case (paddr)
                sdc_pkg::R_FRAME:  d.prdata = {24'h0, q.frame};
                sdc_pkg::R_STATUS: begin
                    d.prdata[sdc_pkg::ST_BUSY] = busy;
                    d.prdata[sdc_pkg::ST_REFU] = q.refused;
                end
                default: d.pslverr = 1'b1;
            endcase
        end

        // serial engine
        if (q.div != 16'h0) begin
            d.div = q.div - 16'h1;
        end else begin
            case (q.st)
                sdc_pkg::H_IDLE: ;
                sdc_pkg::H_LEAD: begin
                    d.st  = sdc_pkg::H_HIGH;
                    d.sck = 1'b1;
                    d.div = HALF_M1;
                end
                sdc_pkg::H_HIGH: begin
                    d.st    = sdc_pkg::H_LOW;
                    d.sck   = 1'b0;
                    d.bits  = q.bits + 4'h1;
                    d.shift = {q.shift[6:0], 1'b0};
                    d.sdat  = q.shift[6];
                    d.div   = HALF_M1;
                end
                sdc_pkg::H_LOW: begin
                    if (q.bits == sdc_pkg::FRAME_CNT) begin
                        d.st   = sdc_pkg::H_TAIL;
                        d.sdat = 1'b0;
                    end else begin
                        d.st  = sdc_pkg::H_HIGH;
                        d.sck = 1'b1;
                    end
                    d.div = HALF_M1;
                end
                sdc_pkg::H_TAIL: begin
                    d.st    = sdc_pkg::H_GAP;
                    d.sel_n = 1'b1;
                    d.div   = HALF_M1;
                end
                sdc_pkg::H_GAP: d.st = sdc_pkg::H_IDLE;
                default: begin
                    d.st    = sdc_pkg::H_IDLE;
                    d.sel_n = 1'b1;
                    d.sck   = 1'b0;
                end
            endcase
        end

        if (acc && q.pready && pwrite) begin
            if (paddr == sdc_pkg::R_FRAME) begin
                if (busy || bad_clk) begin
                    d.refused = 1'b1;
                end else begin
                    d.frame = pwdata[7:0];
                    d.shift = pwdata[7:0];
                    d.sdat  = pwdata[7];
                    d.sel_n = 1'b0;
                    d.bits  = '0;
                    d.st    = sdc_pkg::H_LEAD;
                    d.div   = HALF_M1;
                end
            end else if (paddr == sdc_pkg::R_STATUS && pwdata[sdc_pkg::ST_REFU]) begin
                d.refused = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.st    <= sdc_pkg::H_IDLE;
            q.sel_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata             = q.prdata;
    assign pready             = q.pready;
    assign pslverr            = q.pslverr;
    assign link.host_select_n   = q.sel_n;
    assign link.serial_clock_in = q.sck;
    assign link.serial_data_in  = q.sdat;

endmodule
`default_nettype wire

// ---- dv/sdc_link_props.sv ----
`default_nettype none
module sdc_link_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // serial link
    input wire logic host_select_n,
    input wire logic serial_clock_in,
    input wire logic serial_data_in
);
    logic [3:0] rise_cnt_q;
    logic       sck_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // rising serial clocks seen in the current frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cnt_q <= 4'h0;
            sck_q      <= 1'b0;
        end else begin
            sck_q <= serial_clock_in;
            if (host_select_n) begin
                rise_cnt_q <= 4'h0;
            end else if (serial_clock_in && !sck_q) begin
                rise_cnt_q <= rise_cnt_q + 4'h1;
            end
        end
    end

    AST_EIGHT_BITS: assert property ($rose(host_select_n) |-> rise_cnt_q == 4'h8)
        else $error("frame closed without eight clocks");
    AST_NO_NINTH: assert property (rise_cnt_q == 4'h8 |-> !(serial_clock_in && !sck_q))
        else $error("clock beyond eighth bit");
    AST_IDLE_LEVELS: assert property (host_select_n |-> !serial_clock_in)
        else $error("serial clock high while idle");
    AST_GAP: assert property ($rose(host_select_n) |-> host_select_n[*5])
        else $error("select gap too short");
    AST_LEAD: assert property ($fell(host_select_n) |-> (!serial_clock_in)[*4] ##1 serial_clock_in)
        else $error("first clock not after lead time");
    AST_HIGH_LEN: assert property ($rose(serial_clock_in) |-> serial_clock_in[*4] ##1 !serial_clock_in)
        else $error("clock high phase wrong");
    AST_LOW_LEN: assert property ($fell(serial_clock_in) |-> (!serial_clock_in)[*4])
        else $error("clock low phase too short");
    AST_DATA_HOLD: assert property (serial_clock_in |-> $stable(serial_data_in))
        else $error("data moved while clock high");

    COV_FRAME: cover property ($rose(host_select_n) && rise_cnt_q == 4'h8);
    COV_START: cover property ($fell(host_select_n));
    COV_BIT: cover property ($rose(serial_clock_in) && serial_data_in);
endmodule
`default_nettype wire

// ---- dv/sdc_tb_top.sv ----
`default_nettype none
module sdc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] fr;
        logic [1:0] hr;
        logic [1:0] hc;
        logic [9:0] ex;
    } sdc_row_t;

    // frame, host reset, host clock, {reset, clock, io oe_n, supply en, level}
    localparam sdc_row_t ROWS [8] = '{
        '{8'h6c, 2'h1, 2'h2, 10'h1bc},
        '{8'h07, 2'h2, 2'h1, 10'h17c},
        '{8'h25, 2'h0, 2'h2, 10'h17c},
        '{8'h47, 2'h0, 2'h0, 10'h16c},
        '{8'h9f, 2'h3, 2'h3, 10'h16c},
        '{8'h6f, 2'h0, 2'h0, 10'h16f},
        '{8'h6b, 2'h3, 2'h3, 10'h02b},
        '{8'h63, 2'h3, 2'h3, 10'h003}
    };

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  hrst, hclk, hlow, clow, hio_i, cio_i, hio_oe_n, cio_oe_n;
    logic [1:0]  crst, cclk, sup_en, sup_lv, sup_en2;
    int          error_cnt, n_tests;

    sdc_link_if link ();
    sdc_link_if link2 ();

    // pulled-up open-drain card and host data lines
    assign hio_i = hio_oe_n & ~hlow;
    assign cio_i = cio_oe_n & ~clow;

    sdc_host #(.HALF_CYC(4)) u_sdc_host (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
    sdc_dev u_sdc_dev (.pclk, .presetn, .link(link), .host_card_reset(hrst),
        .host_card_clock(hclk), .host_card_io_i(hio_i), .host_card_io_o(),
        .host_card_io_oe_n(hio_oe_n), .card_reset_out(crst), .card_clock_out(cclk),
        .card_io_i(cio_i), .card_io_o(), .card_io_oe_n(cio_oe_n),
        .card_supply_enable(sup_en), .supply_level_select(sup_lv));
    // second receiver fed by the bench for broken frames
    sdc_dev u_sdc_dev2 (.pclk, .presetn, .link(link2), .host_card_reset(hrst),
        .host_card_clock(hclk), .host_card_io_i(2'h3), .host_card_io_o(),
        .host_card_io_oe_n(), .card_reset_out(), .card_clock_out(),
        .card_io_i(2'h3), .card_io_o(), .card_io_oe_n(),
        .card_supply_enable(sup_en2), .supply_level_select());
    sdc_link_props u_sdc_link_props (.pclk, .presetn,
        .host_select_n(link.host_select_n), .serial_clock_in(link.serial_clock_in),
        .serial_data_in(link.serial_data_in));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // write a frame, then poll busy until the link is idle
    task automatic send(input logic [7:0] fr);
        apb(1'b1, 8'h00, {24'h0, fr});
        rd = 32'h1;
        while (rd[0] !== 1'b0) apb(1'b0, 8'h04, 32'h0);
        repeat (10) @(posedge pclk);
    endtask

    // bench-made frame of n bits, msb first, 400 ns link clock
    task automatic bang(input logic [7:0] fr, input int n);
        link2.host_select_n <= 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            link2.serial_data_in <= fr[i];
            repeat (4) @(posedge pclk);
            link2.serial_clock_in <= 1'b1;
            repeat (4) @(posedge pclk);
            link2.serial_clock_in <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        link2.host_select_n <= 1'b1;
        repeat (12) @(posedge pclk);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, hrst, hclk, hlow, clow} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        n_tests = 0;
        link2.host_select_n = 1'b1;
        link2.serial_clock_in = 1'b0;
        link2.serial_data_in = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({crst, cclk, cio_oe_n, hio_oe_n, sup_en}, 32'h00c);
        foreach (ROWS[i]) begin
            hrst <= ROWS[i].hr;
            hclk <= ROWS[i].hc;
            send(ROWS[i].fr);
            chk({crst, cclk, cio_oe_n, sup_en, sup_lv}, ROWS[i].ex);
        end
        send(8'h6c);
        send(8'h42);
        hlow <= 2'h3;
        repeat (8) @(posedge pclk);
        chk({cio_oe_n, hio_oe_n}, 32'h7);
        hlow <= 2'h0;
        repeat (8) @(posedge pclk);
        clow <= 2'h3;
        repeat (8) @(posedge pclk);
        chk({cio_oe_n, hio_oe_n}, 32'hd);
        clow <= 2'h0;
        apb(1'b1, 8'h00, 32'h24);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h2, 32'h2);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, err}, 32'h1);
        bang(8'h6c, 5);
        chk(sup_en2, 32'h0);
        bang(8'h6c, 8);
        chk(sup_en2, 32'h3);
        test_done();
    end

    initial begin
        #500000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
